// *** shared/port_select_pixel_edge_tally_caps_regs.vh ***
/*
 * Register map, field positions, reset values and the summary of behaviour
 * for the port steering, pixel clock meter and remote capability slice.
 * Assumes it is included by bare name from the design file, once.
 */
// Contract
// - Second-address enable makes the device also answer at primary address plus one.
// - Secondary address accesses reach port 1 registers and shared registers.
// - Port 1 select: primary writes hit port 1 and shared; reads return them.
// - Port 0 select, reset default: primary writes hit port 0 and shared; reads too.
// - Both selects set: reads return port 1; port 0 readable only when port 1 clear.
// - Port select bits are ignored for primary steering while second-address enable set.
// - Writing the meter starts a window of written value oscillator periods.
// - Reading the meter returns pixel edges counted in the latest window.
// - Pixel edge tally saturates at 0xff and never wraps.
// - Capability register is per port; port 1 selection shows the port 1 copy.
// - Back channel auto-loads capability fields once receive lock is seen, unless frozen.
// - Freeze bit blocks auto-load; capability registers keep software-written values.
// - Fast control channel mode is three bits; its lsb is capability bit 6.
// - Capability bit 3 flags two-link capable receiver.
// - Capability bit 2: 0 primary channel, 1 secondary channel.
// - Capability bit 1 flags 24-bit video with high-resolution audio.
// - Capability bit 0 flags I/O carried in the forward frame.
// - Upper two mode bits live in the second capability register; 000 is normal.
`ifndef PORT_SELECT_PIXEL_EDGE_TALLY_CAPS_REGS_VH
`define PORT_SELECT_PIXEL_EDGE_TALLY_CAPS_REGS_VH

// Register offsets
`define TX_PORT_STEERING_ADDR         8'h1e
`define PIXEL_CLOCK_METER_ADDR        8'h1f
`define REMOTE_RECEIVER_CAPS_ONE_ADDR 8'h20

// Reset values
`define TX_PORT_STEERING_RST          8'h01
`define PIXEL_CLOCK_METER_RST         8'h00
`define REMOTE_RECEIVER_CAPS_ONE_RST  8'h00

// Steering fields
`define PRIMARY_PORT_SELECT_BIT       0
`define SECONDARY_PORT_SELECT_BIT     1
`define SECOND_ADDRESS_ENABLE_BIT     2
`define TX_PORT_STEERING_MASK         8'h07

// Capability fields
`define FORWARD_FRAME_IO_SUPPORT_BIT  0
`define VIDEO_WITH_HIRES_AUDIO_BIT    1
`define SECONDARY_CHANNEL_BIT         2
`define TWO_LINK_CAPABLE_BIT          3
`define FAST_CTRL_CHANNEL_MODE_LSB_BIT 6
`define CAPS_FREEZE_BIT               7
`define CAPS_WRITE_MASK               8'hcf
`define CAPS_LOAD_MASK                8'h4f

// Meter limits
`define PIXEL_EDGE_TALLY_MAX          8'hff
`define METER_WINDOW_IDLE             8'h00

// Secondary address offset from the primary device address
`define SECOND_ADDRESS_STEP           7'h01

`endif

// *** core/port_select_pixel_edge_tally_caps.v ***
/*
 * Port steering, pixel clock meter and per-port remote capability registers.
 * Assumes a host-side I2C engine that hands over one decoded access at a time
 * (device address, register offset, data) and the back channel that presents
 * received capability bytes with a one-cycle load strobe. Everything runs on
 * the oscillator clock; the pixel clock arrives as a synchronous level input.
 */
`timescale 1ns/1ps
`default_nettype none

`include "port_select_pixel_edge_tally_caps_regs.vh"

module port_select_pixel_edge_tally_caps #(
   parameter DATA_W = 8,
   parameter DEV_W  = 7
) (
   input  wire              clk,
   input  wire              rst_b,
   input  wire              clk_en,
   input  wire [DEV_W-1:0]  primary_id,
   input  wire              acc_valid,
   input  wire              acc_write,
   input  wire [DEV_W-1:0]  acc_dev,
   input  wire [7:0]        acc_reg,
   input  wire [DATA_W-1:0] acc_wdata,
   input  wire              pix_clk,
   input  wire [1:0]        rx_lock,
   input  wire [1:0]        caps_load,
   input  wire [DATA_W-1:0] caps_in_p0,
   input  wire [DATA_W-1:0] caps_in_p1,
   input  wire [1:0]        mode_upper_p0,
   input  wire [1:0]        mode_upper_p1,
   output reg               acc_ack,
   output reg  [DATA_W-1:0] acc_rdata,
   output reg  [DATA_W-1:0] steering_out,
   output reg  [DATA_W-1:0] caps_p0_out,
   output reg  [DATA_W-1:0] caps_p1_out,
   output reg  [2:0]        fast_ctrl_channel_mode_p0,
   output reg  [2:0]        fast_ctrl_channel_mode_p1,
   output reg               meter_busy
);

   ////////////////////////////////////////////////////////////////////////
   // Registers
   reg [DATA_W-1:0] steering_reg;
   reg [DATA_W-1:0] tally_reg;
   reg [DATA_W-1:0] window_reg;
   reg [DATA_W-1:0] caps_p0_reg;
   reg [DATA_W-1:0] caps_p1_reg;
   reg              pix_last_reg;

   ////////////////////////////////////////////////////////////////////////
   // Address decode and port steering
   wire            second_en  = steering_reg[`SECOND_ADDRESS_ENABLE_BIT];
   wire            sel_p0     = steering_reg[`PRIMARY_PORT_SELECT_BIT];
   wire            sel_p1     = steering_reg[`SECONDARY_PORT_SELECT_BIT];
   wire [DEV_W-1:0] second_id = primary_id + `SECOND_ADDRESS_STEP;
   wire            hit_prim   = acc_valid && (acc_dev == primary_id);
   wire            hit_sec    = acc_valid && second_en && !hit_prim
                                && (acc_dev == second_id);
   wire            hit_any    = hit_prim || hit_sec;

   // With the second address on, the primary address only sees port 0,
   // so the select bits cannot redirect it
   wire prim_p0 = second_en ? 1'b1 : sel_p0;
   wire prim_p1 = second_en ? 1'b0 : sel_p1;

   // Port copies touched by a write
   wire wr_p0 = (hit_prim && prim_p0) && acc_write;
   wire wr_p1 = ((hit_prim && prim_p1) || hit_sec) && acc_write;
   wire wr_shared = hit_any && acc_write;

   // Port copy shown on a read; port 1 wins when both are selected
   wire rd_p1 = hit_sec || (hit_prim && prim_p1);

   wire wr_steer = wr_shared && (acc_reg == `TX_PORT_STEERING_ADDR);
   wire wr_meter = wr_shared && (acc_reg == `PIXEL_CLOCK_METER_ADDR);
   wire wr_caps  = acc_reg == `REMOTE_RECEIVER_CAPS_ONE_ADDR;

   ////////////////////////////////////////////////////////////////////////
   // Read multiplexer; unmapped offsets and reserved bits give zero
   reg [DATA_W-1:0] rdata_next;
   always @* begin
      case (acc_reg)
         `TX_PORT_STEERING_ADDR:         rdata_next = steering_reg;
         `PIXEL_CLOCK_METER_ADDR:        rdata_next = tally_reg;
         `REMOTE_RECEIVER_CAPS_ONE_ADDR: rdata_next = rd_p1 ? caps_p1_reg
                                                            : caps_p0_reg;
         default:                        rdata_next = {DATA_W{1'b0}};
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Steering register and access answer
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         steering_reg <= `TX_PORT_STEERING_RST;
         acc_ack      <= 1'b0;
         acc_rdata    <= {DATA_W{1'b0}};
      end else if (clk_en) begin
         if (wr_steer) begin
            steering_reg <= acc_wdata & `TX_PORT_STEERING_MASK;
         end
         acc_ack   <= hit_any;
         acc_rdata <= (hit_any && !acc_write) ? rdata_next : {DATA_W{1'b0}};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pixel clock meter: window counted in oscillator cycles
   // The pixel clock is sampled, so only rates below half the oscillator
   // rate are counted exactly; faster clocks give a rough low figure.
   wire pix_rise = pix_clk && !pix_last_reg;
   wire counting = (window_reg != `METER_WINDOW_IDLE);

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         window_reg   <= `METER_WINDOW_IDLE;
         tally_reg    <= `PIXEL_CLOCK_METER_RST;
         pix_last_reg <= 1'b0;
      end else if (clk_en) begin
         pix_last_reg <= pix_clk;
         if (wr_meter) begin
            window_reg <= acc_wdata;
            tally_reg  <= `PIXEL_CLOCK_METER_RST;
         end else if (counting) begin
            window_reg <= window_reg - 8'h01;
            if (pix_rise && (tally_reg != `PIXEL_EDGE_TALLY_MAX)) begin
               tally_reg <= tally_reg + 8'h01;
            end
         end
         // Outside a window the tally simply holds
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Capability copies: software writes, back channel loads after lock
   // Software write beats a load in the same cycle, and a write that sets
   // the freeze bit blocks that load as well.
   wire ld_p0 = caps_load[0] && rx_lock[0]
                && !caps_p0_reg[`CAPS_FREEZE_BIT];
   wire ld_p1 = caps_load[1] && rx_lock[1]
                && !caps_p1_reg[`CAPS_FREEZE_BIT];

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         caps_p0_reg <= `REMOTE_RECEIVER_CAPS_ONE_RST;
         caps_p1_reg <= `REMOTE_RECEIVER_CAPS_ONE_RST;
      end else if (clk_en) begin
         if (wr_p0 && wr_caps) begin
            caps_p0_reg <= acc_wdata & `CAPS_WRITE_MASK;
         end else if (ld_p0) begin
            caps_p0_reg <= (caps_p0_reg & ~`CAPS_LOAD_MASK)
                           | (caps_in_p0 & `CAPS_LOAD_MASK);
         end
         if (wr_p1 && wr_caps) begin
            caps_p1_reg <= acc_wdata & `CAPS_WRITE_MASK;
         end else if (ld_p1) begin
            caps_p1_reg <= (caps_p1_reg & ~`CAPS_LOAD_MASK)
                           | (caps_in_p1 & `CAPS_LOAD_MASK);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registered status outputs; mode is upper bits from the second
   // capability register joined with bit 6 of this one
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         steering_out              <= `TX_PORT_STEERING_RST;
         caps_p0_out               <= `REMOTE_RECEIVER_CAPS_ONE_RST;
         caps_p1_out               <= `REMOTE_RECEIVER_CAPS_ONE_RST;
         fast_ctrl_channel_mode_p0 <= 3'h0;
         fast_ctrl_channel_mode_p1 <= 3'h0;
         meter_busy                <= 1'b0;
      end else if (clk_en) begin
         steering_out <= steering_reg;
         caps_p0_out  <= caps_p0_reg;
         caps_p1_out  <= caps_p1_reg;
         fast_ctrl_channel_mode_p0 <= {mode_upper_p0,
            caps_p0_reg[`FAST_CTRL_CHANNEL_MODE_LSB_BIT]};
         fast_ctrl_channel_mode_p1 <= {mode_upper_p1,
            caps_p1_reg[`FAST_CTRL_CHANNEL_MODE_LSB_BIT]};
         meter_busy <= counting;
      end
   end

endmodule // port_select_pixel_edge_tally_caps

`default_nettype wire

// *** sim/port_select_pixel_edge_tally_caps_chk.sv ***
/* Assertions on the port steering, pixel meter and capability slice.
   Assumes one clock domain and is bound to the design's top ports. */
`timescale 1ns/1ps
`default_nettype none
module port_select_pixel_edge_tally_caps_chk (
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic       clk_en,
   input wire logic [6:0] primary_id,
   input wire logic       acc_valid,
   input wire logic [6:0] acc_dev,
   input wire logic [1:0] rx_lock,
   input wire logic [1:0] caps_load,
   input wire logic [7:0] caps_in_p0,
   input wire logic [1:0] mode_upper_p0,
   input wire logic       acc_ack,
   input wire logic [7:0] steering_out,
   input wire logic [7:0] caps_p0_out,
   input wire logic [2:0] fast_ctrl_channel_mode_p0
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Taken access; a quiet cycle before it lets the late steering copy be trusted
   logic prev_valid;
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) prev_valid <= 1'b0;
      else prev_valid <= acc_valid;
   end
   wire tk = acc_valid && clk_en;
   wire sec = tk && acc_dev == primary_id + 7'h01 && acc_dev != primary_id && !prev_valid;
   primary_ack_a: assert property (tk && acc_dev == primary_id |=> acc_ack)
      else $error("primary access not acknowledged");
   address_miss_a: assert property (tk && acc_dev != primary_id
      && acc_dev != primary_id + 7'h01 |=> !acc_ack) else $error("foreign address acknowledged");
   second_off_a: assert property (sec && !steering_out[2] |=> !acc_ack)
      else $error("second address answered while disabled");
   second_on_a: assert property (sec && steering_out[2] |=> acc_ack)
      else $error("second address ignored while enabled");
   reserved_zero_a: assert property (steering_out[7:3] == 5'h00 && caps_p0_out[5:4] == 2'b00)
      else $error("reserved bits not zero");
   mode_track_a: assert property ($past(rst_b) && $past(clk_en) |->
      fast_ctrl_channel_mode_p0 == {$past(mode_upper_p0), caps_p0_out[6]}) else $error("mode bad");
   caps_frozen_a: assert property (caps_p0_out[7] && !acc_valid && !$past(acc_valid)
      && !$past(acc_valid, 2) |=> $stable(caps_p0_out)) else $error("frozen caps changed");
   caps_load_a: assert property (clk_en && caps_load[0] && rx_lock[0] && !caps_p0_out[7]
      && !acc_valid && !$past(acc_valid) |=> ##1
      (caps_p0_out & 8'h4f) == ($past(caps_in_p0, 2) & 8'h4f)) else $error("caps not loaded");
endmodule // port_select_pixel_edge_tally_caps_chk
////////////////////////////////////////////////////////////////////////////////
bind port_select_pixel_edge_tally_caps port_select_pixel_edge_tally_caps_chk chk (.clk(clk), .rst_b(rst_b),
   .clk_en(clk_en), .primary_id(primary_id), .acc_valid(acc_valid), .acc_dev(acc_dev),
   .rx_lock(rx_lock), .caps_load(caps_load), .caps_in_p0(caps_in_p0),
   .mode_upper_p0(mode_upper_p0), .acc_ack(acc_ack), .steering_out(steering_out),
   .caps_p0_out(caps_p0_out), .fast_ctrl_channel_mode_p0(fast_ctrl_channel_mode_p0));
`default_nettype wire

// *** sim/host_model.sv ***
/* Host controller model handing decoded register accesses to the slice.
   Assumes requests change on the falling edge of the bench clock. */
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input  wire logic       clk,
   output var  logic       acc_valid,
   output var  logic       acc_write,
   output var  logic [6:0] acc_dev,
   output var  logic [7:0] acc_reg,
   output var  logic [7:0] acc_wdata,
   input  wire logic       acc_ack,
   input  wire logic [7:0] acc_rdata
);
   initial {acc_valid, acc_write, acc_dev, acc_reg, acc_wdata} = 24'h00;
   // One-cycle request; the answer is taken one cycle later, data then scrambled
   task automatic xfer(input logic [6:0] d, input logic w, input logic [7:0] r,
                       input logic [7:0] v, output logic ack, output logic [7:0] q);
      @(negedge clk);
      {acc_valid, acc_write, acc_dev, acc_reg, acc_wdata} = {1'b1, w, d, r, v};
      @(negedge clk);
      {acc_valid, acc_wdata} = {1'b0, ~v};
      ack = acc_ack;
      q = acc_rdata;
   endtask
endmodule // host_model
`default_nettype wire

// *** sim/port_select_pixel_edge_tally_caps_tb.sv ***
/* Self-checking bench for the steering, meter and capability slice.
   Assumes the host model issues accesses; the bench drives the back channel. */
`timescale 1ns/1ps
`default_nettype none
module port_select_pixel_edge_tally_caps_tb;
   logic       clk = 1'b0;
   logic       rst_b = 1'b0;
   logic       pix_clk = 1'b0;
   logic [1:0] rx_lock = 2'b00;
   logic [1:0] caps_load = 2'b00;
   logic [1:0] mu0 = 2'b00;
   logic [6:0] pid = 7'h10;
   logic [7:0] cin0 = 8'h00, cin1 = 8'h00, rd, q, a, b;
   logic       valid, write, ack;
   logic [6:0] dev;
   logic [7:0] rg, wd;
   logic [2:0] m0, m1;
   logic       ack_line, busy;
   logic [7:0] c1o;
   int         mismatches = 0, total_checks = 0, n;
   always #12.5 clk = ~clk;
   // Free pixel clock, one rising edge every two samples
   always @(negedge clk) pix_clk <= ~pix_clk;
   host_model hm (.clk(clk), .acc_valid(valid), .acc_write(write), .acc_dev(dev),
      .acc_reg(rg), .acc_wdata(wd), .acc_ack(ack_line), .acc_rdata(rd));
   port_select_pixel_edge_tally_caps dut (.clk(clk), .rst_b(rst_b), .clk_en(1'b1), .primary_id(pid),
      .acc_valid(valid), .acc_write(write), .acc_dev(dev), .acc_reg(rg), .acc_wdata(wd),
      .pix_clk(pix_clk), .rx_lock(rx_lock), .caps_load(caps_load), .caps_in_p0(cin0),
      .caps_in_p1(cin1), .mode_upper_p0(mu0), .mode_upper_p1(2'b00), .acc_ack(ack_line),
      .acc_rdata(rd), .steering_out(), .caps_p0_out(), .caps_p1_out(c1o),
      .fast_ctrl_channel_mode_p0(m0), .fast_ctrl_channel_mode_p1(m1), .meter_busy(busy));
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      if (mismatches == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Read shows the port 1 copy only while selected and the second address is off
   function automatic logic [7:0] port_rd(input logic [2:0] s, input logic [7:0] p0, p1);
      return ((s[1] && !s[2]) ? p1 : p0) & 8'hcf;
   endfunction
   task automatic rdc(input logic [6:0] d, input logic [7:0] r, input logic [7:0] e);
      hm.xfer(d, 1'b0, r, 8'h00, ack, q);
      check(q, e);
   endtask
   task automatic wr(input logic [7:0] r, input logic [7:0] v);
      hm.xfer(pid, 1'b1, r, v, ack, q);
      check({7'h00, ack}, 8'h01);
   endtask
   task automatic pulse();
      @(negedge clk) caps_load = 2'b11;
      @(negedge clk) caps_load = 2'b00;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h2867));
      pid = 7'($urandom_range(100, 8));
      repeat (3) @(negedge clk);
      rst_b = 1'b1;
      rdc(pid, 8'h1e, 8'h01);
      rdc(pid, 8'h20, 8'h00);
      rdc(pid, 8'h21, 8'h00);
      wr(8'h1e, 8'hff);
      rdc(pid, 8'h1e, 8'h07);
      a = 8'($urandom) & 8'h7f;
      b = 8'($urandom) & 8'h7f;
      wr(8'h1e, 8'h01);
      wr(8'h20, a | 8'h30);
      wr(8'h1e, 8'h02);
      wr(8'h20, b);
      // Every select combination, the second address enable among them
      for (n = 0; n < 8; n++) begin
         wr(8'h1e, 8'(n));
         rdc(pid, 8'h20, port_rd(3'(n), a, b));
      end
      rdc(pid + 7'h01, 8'h20, b & 8'hcf);
      wr(8'h1e, 8'h01);
      hm.xfer(pid + 7'h01, 1'b0, 8'h20, 8'h00, ack, q);
      check({7'h00, ack}, 8'h00);
      rx_lock = 2'b11;
      {cin0, cin1, mu0} = 18'($urandom);
      pulse();
      rdc(pid, 8'h20, cin0 & 8'h4f);
      check(8'(m0), 8'({mu0, cin0[6]}));
      wr(8'h1e, 8'h02);
      rdc(pid, 8'h20, cin1 & 8'h4f);
      wr(8'h20, b | 8'h80);
      cin1 = ~cin1;
      pulse();
      rdc(pid, 8'h20, (b | 8'h80) & 8'hcf);
      check(c1o, (b | 8'h80) & 8'hcf);
      check(8'(m1), 8'({2'b00, b[6]}));
      n = $urandom_range(60, 20);
      wr(8'h1f, 8'(n));
      @(negedge clk);
      check({7'h00, busy}, 8'h01);
      repeat (n + 4) @(negedge clk);
      check({7'h00, busy}, 8'h00);
      // Edge alignment at the window ends leaves one count of slack, twice over
      repeat (2) begin
         hm.xfer(pid, 1'b0, 8'h1f, 8'h00, ack, q);
         check(8'(q >= n / 2 - 1 && q <= n / 2 + 1), 8'h01);
      end
      wr(8'h1f, 8'h00);
      rdc(pid, 8'h1f, 8'h00);
      final_report();
   end
   // Watchdog well beyond the roughly 150 cycles the sequence needs
   initial begin
      #75000;
      mismatches++;
      final_report();
   end
endmodule // port_select_pixel_edge_tally_caps_tb
`default_nettype wire
